// File: inc/event_filter_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the event filter.
// Assumes: 25 MHz system clock, 32-bit classic Wishbone register port.
// Notes: Byte addresses; filter table entries take two words each.
`ifndef EVENT_FILTER_MAP_SVH
`define EVENT_FILTER_MAP_SVH

// ****************************************
// Register map
// ****************************************
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_FEEDBACK 12'h008
`define REG_ALERT_POLICY 12'h00c
`define TABLE_BASE_HI 4'h1

// ****************************************
// Fields
// ****************************************
`define CTRL_FILTER_EN 0
`define CTRL_LOG_EN 1
`define CTRL_FB_PINS 2
`define CTRL_RESET 32'h0000_0001
`define ENT_EN 31
`define ENT_SENSOR_HI 23
`define ENT_SENSOR_LO 16
`define ENT_ANY_SENSOR 8'hff
`define ACT_DELAY_HI 23
`define ACT_DELAY_LO 16
`define ALERT_POLICY_VALUE 32'h0000_0011
`define INTERNAL_SENSOR_FIRST 8'h01
`define INTERNAL_SENSOR_LAST 8'h08

// ****************************************
// Action indices, lowest index runs first
// ****************************************
`define ACT_POWER_DOWN 0
`define ACT_SOFT_OFF 1
`define ACT_POWER_CYCLE 2
`define ACT_RESET 3
`define ACT_DIAG_INT 4
`define ACT_TRAP 5
`define ACT_SENSOR_FB 6
`define ACT_IPMB_EVT 7
`define ACT_FAULT_LED 8
`define ACT_ID_LED 9
`define SKIP_ON_POWER_DOWN 10'h01e

// ****************************************
// Timing
// ****************************************
`define CLK_KHZ 25000
`define DELAY_UNIT_MS 100
`define NMI_PULSE_MS 200
`define BUTTON_PULSE_MS 1
`define MAX_DELAY_UNITS 8'hff

`endif

// File: inc/event_filter_pkg.sv
// Purpose: Types shared by the event filter and its surroundings.
// Assumes: Nothing beyond the map header.
// Notes: Sensor numbers and offsets as carried by platform event messages.
package event_filter_pkg;

  typedef struct packed {
    logic [7:0] sensor;
    logic [3:0] offset;
    logic asserted;
    logic external;
  } event_t;

  typedef struct packed {
    logic [7:0] sensor;
    logic [3:0] offset;
    logic asserted;
  } trap_t;

  typedef struct packed {
    logic [3:0] action;
    logic [7:0] sensor;
  } log_t;

endpackage : event_filter_pkg

// File: hdl/platform_event_filter.sv
// Purpose: Event filter table, action arbitration and action dispatch.
// Assumes: Event sources and power/LED logic sit outside; inputs synchronous to clk_i.
// Notes: Registers over classic Wishbone; one action dispatched per clock.
//
// Summary of operation
// - Thirty configurable filter entries decide actions per incoming event.
// - One alert policy entry, fixed and read only.
// - No alert strings; traps carry only event information.
// - Every internal or external event is compared against the filter table.
// - All entries are examined; matching actions are merged before any runs.
// - Merged actions run one at a time in ascending priority.
// - Power-down, soft-off, power cycle, reset delay in 100 ms units, capped.
// - An action turned undelayed or shortened jumps ahead of other pending ones.
// - Optionally each executed action is logged as an event log entry.
// - Soft-shutdown pulses the ACPI power button signal.
// - Device feedback issues a peripheral SMBus transaction or drives feedback pins.
// - Power cycle priority 3, reset priority 4, delayable, skipped with power-down.
// - Soft-off, cycle, reset, diagnostic interrupt skipped when power-down selected.
// - Trap alert has priority 6 and no delay.
// - Sensor feedback 7, IPMB event 8, fault LED 9, ID LED 10, undelayed.
// - Undelayed actions start as soon as the selecting event is seen.
// - Fault LED blinks until all requesting critical events deassert.
// - LAN alerts leave as platform event trap requests, host state ignored.
// - Sensors 01h to 08h are event-only; reading them answers an error.
// - Diagnostic interrupt pulse lasts 200 ms, once until reset or power-down.
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "event_filter_map.svh"

module platform_event_filter
  import event_filter_pkg::*;
#(
  parameter int unsigned NUM_ENTRIES = 30,
  parameter int unsigned TICK_CYCLES = `CLK_KHZ * `DELAY_UNIT_MS,
  parameter int unsigned NMI_CYCLES = `CLK_KHZ * `NMI_PULSE_MS,
  parameter int unsigned BUTTON_CYCLES = `CLK_KHZ * `BUTTON_PULSE_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic event_valid_i,
  input wire event_t event_i,
  output logic event_ready_o,
  input wire logic query_valid_i,
  input wire logic [7:0] query_sensor_i,
  output logic query_done_o,
  output logic query_err_o,
  input wire logic sys_reset_i,
  output logic power_down_o,
  output logic power_button_o,
  output logic power_cycle_o,
  output logic reset_req_o,
  output logic nmi_o,
  output logic trap_valid_o,
  output trap_t trap_o,
  output logic fb_smb_req_o,
  output logic [15:0] fb_smb_word_o,
  output logic [7:0] feedback_io_pins_o,
  output logic ipmb_evt_o,
  output logic fault_led_o,
  output logic id_led_o,
  output logic log_valid_o,
  output log_t log_o
);

  localparam int unsigned NUM_ACT = 10;
  localparam int unsigned NUM_DLY = 4;

  // ****************************************
  // Parameter check
  // ****************************************
  if (NUM_ENTRIES < 1 || NUM_ENTRIES > 32 || TICK_CYCLES < 2 || NMI_CYCLES < 1
      || BUTTON_CYCLES < 1) begin : g_bad_param
    $error("platform_event_filter: unsupported parameter value");
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] ctrl;
  logic [31:0] fbreg;
  logic [31:0] ent_cfg [NUM_ENTRIES];
  logic [31:0] ent_act [NUM_ENTRIES];
  logic [NUM_ACT-1:0] pend;
  logic nmi_lock;
  logic [NUM_ENTRIES-1:0] blink_req;
  logic ev_v;

  wire req = cyc_i && stb_i && !ack_o;
  wire in_table = adr_i[11:8] == `TABLE_BASE_HI && 32'(adr_i[7:3]) < NUM_ENTRIES;
  wire [4:0] ent_idx = adr_i[7:3];
  wire wr = req && we_i;
  wire [31:0] bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] status_word = {18'h0, ev_v, |blink_req, nmi_lock, 1'b0, pend};
  wire [31:0] ent_word = adr_i[2] ? ent_act[ent_idx] : ent_cfg[ent_idx];
  wire [31:0] rd_word = in_table ? ent_word :
                        adr_i == `REG_CTRL ? ctrl :
                        adr_i == `REG_STATUS ? status_word :
                        adr_i == `REG_FEEDBACK ? fbreg :
                        adr_i == `REG_ALERT_POLICY ? `ALERT_POLICY_VALUE : 32'h0;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
      ctrl <= `CTRL_RESET;
      fbreg <= 32'h0;
      for (int e = 0; e < NUM_ENTRIES; e++) begin
        ent_cfg[e] <= 32'h0;
        ent_act[e] <= 32'h0;
      end
    end else begin
      ack_o <= req;
      dat_o <= req && !we_i ? rd_word : 32'h0;
      if (wr && adr_i == `REG_CTRL) begin
        ctrl <= merge(ctrl, dat_i, bmask) & 32'h7;
      end
      if (wr && adr_i == `REG_FEEDBACK) begin
        fbreg <= merge(fbreg, dat_i, bmask) & 32'h00ff_ffff;
      end
      if (wr && in_table && !adr_i[2]) begin
        ent_cfg[ent_idx] <= merge(ent_cfg[ent_idx], dat_i, bmask);
      end
      if (wr && in_table && adr_i[2]) begin
        ent_act[ent_idx] <= merge(ent_act[ent_idx], dat_i, bmask) & 32'h00ff_03ff;
      end
    end
  end

  // ****************************************
  // Event capture and table match
  // ****************************************
  event_t ev_q;
  wire filter_en = ctrl[`CTRL_FILTER_EN];
  logic [NUM_ENTRIES-1:0] hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_v <= 1'b0;
      ev_q <= '0;
      event_ready_o <= 1'b0;
    end else begin
      ev_v <= event_valid_i && event_ready_o;
      if (event_valid_i && event_ready_o) begin
        ev_q <= event_i;
      end
      event_ready_o <= !(event_valid_i && event_ready_o);
    end
  end

  for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_match
    wire [7:0] want = ent_cfg[g][`ENT_SENSOR_HI:`ENT_SENSOR_LO];
    assign hit[g] = ent_cfg[g][`ENT_EN] && ent_cfg[g][ev_q.offset]
                    && (want == `ENT_ANY_SENSOR || want == ev_q.sensor);
  end

  logic [NUM_ACT-1:0] union_act;
  logic [7:0] min_dly [NUM_DLY];
  logic [NUM_ENTRIES-1:0] fault_hits;

  always_comb begin
    union_act = '0;
    fault_hits = '0;
    for (int d = 0; d < NUM_DLY; d++) begin
      min_dly[d] = `MAX_DELAY_UNITS;
    end
    for (int e = 0; e < NUM_ENTRIES; e++) begin
      if (hit[e]) begin
        union_act = union_act | ent_act[e][NUM_ACT-1:0];
        fault_hits[e] = ent_act[e][`ACT_FAULT_LED];
        for (int d = 0; d < NUM_DLY; d++) begin
          if (ent_act[e][d] && ent_act[e][`ACT_DELAY_HI:`ACT_DELAY_LO] < min_dly[d]) begin
            min_dly[d] = ent_act[e][`ACT_DELAY_HI:`ACT_DELAY_LO];
          end
        end
      end
    end
  end

  wire take = ev_v && filter_en && ev_q.asserted;
  wire pd_sel = union_act[`ACT_POWER_DOWN];
  wire [NUM_ACT-1:0] skip = pd_sel ? `SKIP_ON_POWER_DOWN : 10'h000;
  wire [NUM_ACT-1:0] new_act = take ? (union_act & ~skip) : 10'h000;

  // ****************************************
  // Pending actions and arbitration
  // ****************************************
  logic [7:0] cnt [NUM_DLY];
  logic [NUM_DLY-1:0] boost;
  logic [31:0] tick_cnt;
  logic tick;
  logic [NUM_ACT-1:0] rdy;
  logic [3:0] pick;
  logic pick_v;

  always_comb begin
    for (int i = 0; i < NUM_ACT; i++) begin
      rdy[i] = pend[i] && (i >= NUM_DLY || cnt[i % NUM_DLY] == 8'h00);
    end
    pick = 4'h0;
    pick_v = 1'b0;
    for (int i = NUM_ACT - 1; i >= 0; i--) begin
      if (rdy[i]) begin
        pick = 4'(i);
        pick_v = 1'b1;
      end
    end
    for (int i = NUM_DLY - 1; i >= 0; i--) begin
      if (rdy[i] && boost[i] && !(pick_v && pick == 4'(i) && boost[pick[1:0]])) begin
        pick = 4'(i);
      end
    end
  end

  wire [NUM_ACT-1:0] done = pick_v ? (10'h001 << pick) : 10'h000;
  wire kill = pd_sel && take;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == TICK_CYCLES - 1;
      tick_cnt <= tick_cnt == TICK_CYCLES - 1 ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= '0;
      boost <= '0;
      for (int d = 0; d < NUM_DLY; d++) begin
        cnt[d] <= 8'h00;
      end
    end else begin
      for (int i = NUM_DLY; i < NUM_ACT; i++) begin
        pend[i] <= new_act[i] || (pend[i] && !done[i]);
      end
      for (int d = 0; d < NUM_DLY; d++) begin
        if (kill && d != `ACT_POWER_DOWN) begin
          pend[d] <= 1'b0;
          boost[d] <= 1'b0;
        end else if (new_act[d] && !pend[d]) begin
          pend[d] <= 1'b1;
          cnt[d] <= min_dly[d];
          boost[d] <= 1'b0;
        end else if (new_act[d] && min_dly[d] < cnt[d]) begin
          cnt[d] <= min_dly[d];
          boost[d] <= 1'b1;
        end else if (done[d]) begin
          pend[d] <= 1'b0;
          boost[d] <= 1'b0;
        end else if (tick && pend[d] && cnt[d] != 8'h00) begin
          cnt[d] <= cnt[d] - 8'h01;
          if (cnt[d] == 8'h01) begin
            boost[d] <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Action dispatch
  // ****************************************
  logic [31:0] nmi_cnt;
  logic [31:0] btn_cnt;
  logic [NUM_ENTRIES-1:0] blink_stage;
  logic blink_phase;
  event_t act_ev;
  wire run_nmi = done[`ACT_DIAG_INT] && !nmi_lock;
  wire unlock = sys_reset_i || done[`ACT_POWER_DOWN];
  wire drop = ev_v && !ev_q.asserted;
  wire fb_pins = ctrl[`CTRL_FB_PINS];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_ev <= '0;
      power_down_o <= 1'b0;
      power_cycle_o <= 1'b0;
      reset_req_o <= 1'b0;
      power_button_o <= 1'b0;
      btn_cnt <= 32'h0;
      nmi_o <= 1'b0;
      nmi_cnt <= 32'h0;
      nmi_lock <= 1'b0;
      trap_valid_o <= 1'b0;
      trap_o <= '0;
      fb_smb_req_o <= 1'b0;
      fb_smb_word_o <= 16'h0;
      feedback_io_pins_o <= 8'h00;
      ipmb_evt_o <= 1'b0;
      blink_stage <= '0;
      blink_req <= '0;
      blink_phase <= 1'b0;
      fault_led_o <= 1'b0;
      id_led_o <= 1'b0;
      log_valid_o <= 1'b0;
      log_o <= '0;
      query_done_o <= 1'b0;
      query_err_o <= 1'b0;
    end else begin
      if (take) begin
        act_ev <= ev_q;
      end
      power_down_o <= done[`ACT_POWER_DOWN];
      power_cycle_o <= done[`ACT_POWER_CYCLE];
      reset_req_o <= done[`ACT_RESET];
      if (done[`ACT_SOFT_OFF]) begin
        btn_cnt <= BUTTON_CYCLES;
      end else if (btn_cnt != 32'h0) begin
        btn_cnt <= btn_cnt - 32'h1;
      end
      power_button_o <= done[`ACT_SOFT_OFF] || btn_cnt > 32'h1;
      if (run_nmi) begin
        nmi_cnt <= NMI_CYCLES;
      end else if (nmi_cnt != 32'h0) begin
        nmi_cnt <= nmi_cnt - 32'h1;
      end
      nmi_o <= run_nmi || nmi_cnt > 32'h1;
      nmi_lock <= run_nmi || (nmi_lock && !unlock);
      trap_valid_o <= done[`ACT_TRAP];
      if (done[`ACT_TRAP]) begin
        trap_o <= '{sensor: act_ev.sensor, offset: act_ev.offset, asserted: 1'b1};
      end
      fb_smb_req_o <= done[`ACT_SENSOR_FB] && !fb_pins;
      if (done[`ACT_SENSOR_FB] && !fb_pins) begin
        fb_smb_word_o <= fbreg[23:8];
      end
      if (done[`ACT_SENSOR_FB] && fb_pins) begin
        feedback_io_pins_o <= fbreg[7:0];
      end
      ipmb_evt_o <= done[`ACT_IPMB_EVT];
      if (drop) begin
        blink_stage <= blink_stage & ~hit & ~{NUM_ENTRIES{done[`ACT_FAULT_LED]}};
      end else if (take) begin
        blink_stage <= done[`ACT_FAULT_LED] ? fault_hits : (blink_stage | fault_hits);
      end else if (done[`ACT_FAULT_LED]) begin
        blink_stage <= '0;
      end
      // Start of blinking wins over a same-cycle deassertion
      if (done[`ACT_FAULT_LED]) begin
        blink_req <= (blink_req & ~(drop ? hit : '0)) | blink_stage;
      end else if (drop) begin
        blink_req <= blink_req & ~hit;
      end
      if (tick) begin
        blink_phase <= !blink_phase;
      end
      fault_led_o <= |blink_req && blink_phase;
      if (done[`ACT_ID_LED]) begin
        id_led_o <= !id_led_o;
      end
      log_valid_o <= pick_v && ctrl[`CTRL_LOG_EN];
      if (pick_v) begin
        log_o <= '{action: pick, sensor: act_ev.sensor};
      end
      query_done_o <= query_valid_i;
      query_err_o <= query_valid_i && query_sensor_i >= `INTERNAL_SENSOR_FIRST
                     && query_sensor_i <= `INTERNAL_SENSOR_LAST;
    end
  end

endmodule : platform_event_filter

`default_nettype wire

// File: bench/event_source.sv
// Purpose: Far-side event source offering platform event messages.
// Assumes: Requests are one-cycle pulses, never while an offer is open.
// Notes: After a take the event bus shows the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none

module event_source
  import event_filter_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire event_t ev_i,
  input wire logic ready_i,
  output logic valid_o,
  output event_t event_o
);
  // ****************************************
  // Offer held until taken
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      event_o <= '0;
    end else if (send_i) begin
      valid_o <= 1'b1;
      event_o <= ev_i;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      event_o <= event_t'(~event_o);
    end
  end
endmodule : event_source

`default_nettype wire

// File: bench/event_filter_sva.sv
// Purpose: Port-level checks of the event filter.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes: Bound to every instance of the design.
`timescale 1ns/1ns
`default_nettype none

module event_filter_sva
  import event_filter_pkg::*;
#(
  parameter int unsigned NMI_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic query_valid_i,
  input wire logic [7:0] query_sensor_i,
  input wire logic query_done_o,
  input wire logic query_err_o,
  input wire logic event_valid_i,
  input wire logic event_ready_o,
  input wire logic power_down_o,
  input wire logic power_cycle_o,
  input wire logic reset_req_o,
  input wire logic nmi_o,
  input wire logic sys_reset_i,
  input wire logic trap_valid_o,
  input wire trap_t trap_o
);
  int unsigned nmi_len;
  logic nmi_lock;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // Helpers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_len <= 0;
      nmi_lock <= 1'b0;
    end else begin
      nmi_len <= nmi_o ? nmi_len + 1 : 0;
      nmi_lock <= $rose(nmi_o) ? 1'b1 : ((sys_reset_i || power_down_o) ? 1'b0 : nmi_lock);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o && !$past(ack_o))
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_data_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_query_done: assert property (query_valid_i |=> query_done_o)
    else $error("query not answered");
  a_query_err_range: assert property (query_valid_i |=>
    query_err_o == ($past(query_sensor_i) inside {[8'h01:8'h08]}))
    else $error("query error flag wrong");
  a_power_down_excl: assert property (power_down_o |->
    (!power_cycle_o && !reset_req_o)[*8])
    else $error("cycle or reset beside power-down");
  a_nmi_width: assert property ($fell(nmi_o) |-> nmi_len == NMI_CYCLES)
    else $error("diagnostic pulse width wrong");
  a_nmi_once: assert property ($rose(nmi_o) |-> !nmi_lock)
    else $error("second diagnostic pulse before re-arm");
  a_trap_asserted: assert property (trap_valid_o |-> trap_o.asserted)
    else $error("trap without asserted flag");
  a_ready_drop: assert property (event_valid_i && event_ready_o |=> !event_ready_o)
    else $error("ready held after take");
endmodule : event_filter_sva

bind platform_event_filter event_filter_sva #(.NMI_CYCLES(NMI_CYCLES)) i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
  .query_valid_i(query_valid_i), .query_sensor_i(query_sensor_i),
  .query_done_o(query_done_o), .query_err_o(query_err_o), .event_valid_i(event_valid_i),
  .event_ready_o(event_ready_o), .power_down_o(power_down_o), .power_cycle_o(power_cycle_o),
  .reset_req_o(reset_req_o), .nmi_o(nmi_o), .sys_reset_i(sys_reset_i),
  .trap_valid_o(trap_valid_o), .trap_o(trap_o));

`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench of the event filter.
// Assumes: Shortened tick, pulse and button counts.
// Notes: Counters watch outputs on rising edges; checks run on falling edges, register read checks on rising edges.
`timescale 1ns/1ns
`default_nettype none
`include "event_filter_map.svh"

module tb
  import event_filter_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic qv = 1'b0, sysr = 1'b0, send = 1'b0, nmi_q, pb_q;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000, rd, dat_o;
  logic [7:0] qs = 8'h00;
  event_t evin = '0, evo;
  logic ack, rdy, qd, qe, pd, pb, pc, rr, nmi, tv, smb, ipmb, idl, lv, evv, fled;
  logic [7:0] fbp;
  logic [15:0] smbw;
  trap_t trap;
  log_t lg;
  int n_fail = 0, check_count = 0, cycles = 0, t_take, t_pd, t_trap;
  int n_pd, n_pc, n_rr, n_tr, n_nmi, n_btn, n_smb, n_ipmb, n_log, n_led;

  always #20 clk = ~clk;

  event_source i_src (.clk_i(clk), .rst_i(rst), .send_i(send), .ev_i(evin), .ready_i(rdy),
    .valid_o(evv), .event_o(evo));

  platform_event_filter #(.TICK_CYCLES(8), .NMI_CYCLES(20), .BUTTON_CYCLES(4)) i_dut (
    .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat), .sel_i(4'hf), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o), .ack_o(ack), .event_valid_i(evv),
    .event_i(evo), .event_ready_o(rdy), .query_valid_i(qv), .query_sensor_i(qs),
    .query_done_o(qd), .query_err_o(qe), .sys_reset_i(sysr), .power_down_o(pd),
    .power_button_o(pb), .power_cycle_o(pc), .reset_req_o(rr), .nmi_o(nmi),
    .trap_valid_o(tv), .trap_o(trap), .fb_smb_req_o(smb), .fb_smb_word_o(smbw),
    .feedback_io_pins_o(fbp), .ipmb_evt_o(ipmb), .fault_led_o(fled), .id_led_o(idl),
    .log_valid_o(lv), .log_o(lg));

  // ****************************************
  // Output monitor and timeout
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (evv === 1'b1 && rdy === 1'b1) t_take = cycles;
    if (pd === 1'b1) begin n_pd++; t_pd = cycles; end
    if (tv === 1'b1) begin n_tr++; t_trap = cycles; end
    if (pc === 1'b1) n_pc++;
    if (rr === 1'b1) n_rr++;
    if (smb === 1'b1) n_smb++;
    if (ipmb === 1'b1) n_ipmb++;
    if (lv === 1'b1) n_log++;
    if (fled === 1'b1) n_led++;
    if (nmi === 1'b1 && nmi_q !== 1'b1) n_nmi++;
    if (pb === 1'b1 && pb_q !== 1'b1) n_btn++;
    nmi_q = nmi;
    pb_q = pb;
    if (cycles > 4000) begin n_fail++; tally_and_finish(); end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt

  task wb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a; we <= w; wdat <= d; cyc <= 1'b1; stb <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb

  task ent(input int i, input logic [31:0] w0, input logic [31:0] w1);
    wb(12'h100 + 12'(8 * i), 1'b1, w0);
    wb(12'h104 + 12'(8 * i), 1'b1, w1);
  endtask : ent

  task ev(input logic [7:0] s, input logic a, input int n);
    @(posedge clk);
    send <= 1'b1;
    evin <= '{sensor: s, offset: 4'h3, asserted: a, external: 1'b1};
    @(posedge clk);
    send <= 1'b0;
    wt(n);
  endtask : ev

  task qry(input logic [7:0] s, input logic e);
    @(posedge clk); qv <= 1'b1; qs <= s;
    @(posedge clk); qv <= 1'b0;
    @(negedge clk);
    chk(qd, 1'b1);
    chk(qe, e);
  endtask : qry

  task clr();
    n_pd = 0; n_pc = 0; n_rr = 0; n_tr = 0; n_nmi = 0;
    n_btn = 0; n_smb = 0; n_ipmb = 0; n_log = 0; n_led = 0;
  endtask : clr

  task tally_and_finish();
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(`REG_CTRL, 1'b0, 32'h0); chk(rd, `CTRL_RESET);
    wb(`REG_ALERT_POLICY, 1'b1, 32'hffff_ffff);
    wb(`REG_ALERT_POLICY, 1'b0, 32'h0); chk(rd, `ALERT_POLICY_VALUE);
    wb(12'hffc, 1'b0, 32'h0); chk(rd, 32'h0);
    qry(8'h00, 1'b0); qry(8'h01, 1'b1); qry(8'h08, 1'b1); qry(8'h09, 1'b0);
    // Power-down with cycle, reset and trap in one set
    ent(0, 32'h800a_ffff, 32'h0000_002d); clr(); ev(8'h0a, 1'b1, 30);
    chk(n_pd, 1);
    chk(n_pc + n_rr, 0);
    chk(n_tr, 1);
    chk(t_pd < t_trap, 1'b1);
    chk(t_pd - t_take <= 4, 1'b1);
    chk(trap.sensor, 8'h0a);
    // Delayed soft-off and reset, two units
    ent(0, 32'h0, 32'h0); ent(1, 32'h800b_ffff, 32'h0002_000a); clr(); ev(8'h0b, 1'b1, 6);
    chk(n_rr + n_btn, 0);
    wt(40);
    chk(n_rr, 1);
    chk(n_btn, 1);
    // Union of two entries, last table slot, logging on
    ent(1, 32'h0, 32'h0); wb(`REG_FEEDBACK, 1'b1, 32'h0012_345a); wb(`REG_CTRL, 1'b1, 32'h3);
    ent(2, 32'h800c_ffff, 32'h0000_00c0); ent(29, 32'h800c_ffff, 32'h0000_0200);
    clr(); ev(8'h0c, 1'b1, 30);
    chk(n_ipmb, 1);
    chk(idl, 1'b1);
    chk(n_smb, 1);
    chk(smbw, 16'h1234);
    chk(n_log, 3);
    chk(lg.action, 4'h9);
    // Diagnostic pulse once until re-armed
    wb(`REG_CTRL, 1'b1, 32'h1); ent(29, 32'h0, 32'h0); ent(2, 32'h80ff_ffff, 32'h0000_0010);
    clr(); ev(8'h0d, 1'b1, 30); ev(8'h0d, 1'b1, 30);
    chk(n_nmi, 1);
    @(posedge clk); sysr <= 1'b1;
    @(posedge clk); sysr <= 1'b0;
    ev(8'h0d, 1'b0, 30);
    chk(n_nmi, 1);
    ev(8'h0d, 1'b1, 30);
    chk(n_nmi, 2);
    // Fault LED blinks until its event deasserts, feedback on pins
    wb(`REG_CTRL, 1'b1, 32'h5); ent(2, 32'h800e_ffff, 32'h0000_0140);
    clr(); ev(8'h0e, 1'b1, 30);
    chk(fbp, 8'h5a);
    chk(n_smb, 0);
    chk(n_led > 0, 1'b1);
    ev(8'h0e, 1'b0, 4); clr(); wt(20);
    chk(n_led, 0);
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
